// File: smart_log_pkg.sv
// constants, types and layouts for the smart log sector builder
package smart_log_pkg;
  // ------------------------------------------------------------
  // register map (apb byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_TIMES = 8'h10;
  localparam logic [7:0] OFF_ATTR = 8'h14;
  localparam logic [2:0] KIND_THRESH = 3'h0;
  localparam logic [2:0] KIND_DIR = 3'h1;
  localparam logic [2:0] KIND_ERRLOG = 3'h2;
  localparam logic [2:0] KIND_SELFTEST = 3'h3;
  // ------------------------------------------------------------
  // sector layouts
  // ------------------------------------------------------------
  localparam logic [15:0] THR_REV = 16'h0010;
  localparam logic [8:0] THR_BASE = 9'h002;
  localparam logic [8:0] THR_END = 9'h16a;
  localparam int THR_ENTRY = 12;
  localparam int THR_VAL_OFF = 1;
  localparam logic [7:0] DIR_VERSION = 8'h01;
  localparam logic [7:0] DIR_WIDE_LO = 8'h80;
  localparam logic [7:0] DIR_WIDE_HI = 8'h9f;
  localparam logic [7:0] DIR_WIDE_SECTORS = 8'h10;
  localparam logic [7:0] ERR_VERSION = 8'h01;
  localparam logic [8:0] ERR_BASE = 9'h002;
  localparam logic [8:0] ERR_COUNT_OFF = 9'h1c4;
  localparam int ERR_REC_LEN = 90;
  localparam int ERR_CMD_LEN = 12;
  localparam int ERR_CMD_REGS = 8;
  localparam int ERR_DATA_OFF = 60;
  localparam int ERR_STATE_OFF = 27;
  localparam int ERR_HOURS_OFF = 28;
  localparam int ERR_SLOTS = 5;
  localparam logic [2:0] RST_ERR_IDX = 3'h1;
  localparam logic [8:0] ST_BASE = 9'h002;
  localparam logic [8:0] ST_END = 9'h1fa;
  localparam logic [8:0] ST_INDEX_OFF = 9'h1fc;
  localparam int ST_DESC_LEN = 24;
  localparam int ST_SLOTS = 21;
  localparam logic [8:0] LAST_SUMMED = 9'h1fe;
  localparam logic [8:0] CSUM_OFF = 9'h1ff;
  localparam int CAP_AUTOSAVE_BIT = 1;
  localparam int ERRLOG_CAP_BIT = 0;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_UNKNOWN = 4'h0,
    ST_SLEEP = 4'h1,
    ST_STANDBY = 4'h2,
    ST_ACTIVE = 4'h3,
    ST_OFFLINE = 4'h4
  } dev_state_t;
  typedef struct packed {
    logic [7:0] dev_ctrl, features, sec_cnt, sec_num;
    logic [7:0] cyl_lo, cyl_hi, dev_head, command;
    logic [31:0] stamp_ms;
  } cmd_rec_t;
  typedef struct packed {
    logic [7:0] error, sec_cnt, sec_num, cyl_lo;
    logic [7:0] cyl_hi, dev_head, status;
    logic [3:0] state_vendor;
    dev_state_t state_code;
    logic [15:0] hours;
  } err_rec_t;
  typedef struct packed {
    cmd_rec_t [4:0] cmds;
    err_rec_t err;
  } err_event_t;
  typedef struct packed {
    logic [7:0] number, status;
    logic [15:0] hours;
    logic [7:0] checkpoint;
    logic [31:0] lba;
  } selftest_t;
  typedef struct packed {
    logic [7:0] short_min, ext_min;
    logic [15:0] ext_word;
  } times_t;
endpackage : smart_log_pkg

// File: smart_log_sector_builder.sv
// smart log sector builder with apb register access
`timescale 1ns/10ps
`default_nettype none
module smart_log_sector_builder
  import smart_log_pkg::*;
#(
  parameter int ATTR_SLOTS = 30,
  parameter logic [ATTR_SLOTS-1:0][7:0] THRESH_VALUES = '0,
  parameter logic [15:0] ST_REVISION = 16'h0001
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [ATTR_SLOTS-1:0][7:0] attr_id,
  input wire logic [7:0] attr_partial_sum,
  input wire logic prepower_save,
  input wire logic autosave_supported,
  input wire logic errlog_supported,
  input wire logic err_valid,
  input wire err_event_t err_event,
  input wire logic st_valid,
  input wire selftest_t st_result,
  output logic [15:0] smart_cap,
  output logic [7:0] errlog_cap,
  output times_t times,
  output logic [7:0] attr_checksum
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_RUN = 2'b10
  } scan_state_t;
  err_event_t err_slot [ERR_SLOTS];
  selftest_t st_slot [ST_SLOTS];
  logic [2:0] err_idx;
  logic [15:0] err_count;
  logic [4:0] st_idx;
  logic [ATTR_SLOTS-1:0][7:0] attr_id_q;
  logic [2:0] kind;
  logic [8:0] addr;
  logic [7:0] csum [3];
  logic [2:0] dirty;
  logic [2:0] dirty_set;
  logic [2:0] dirty_clr;
  scan_state_t scan_state;
  logic [1:0] scan_sel;
  logic [8:0] scan_addr;
  logic [7:0] scan_acc;
  logic [7:0] scan_byte;
  logic [1:0] next_sel;
  logic acc_setup, acc_done, wr, mapped;

  // ------------------------------------------------------------
  // byte generators
  // ------------------------------------------------------------
  function automatic logic [7:0] cmd_byte(input cmd_rec_t c,
                                          input int b);
    logic [7:0] r;
    r = 8'h00;
    case (b)
      0: r = c.dev_ctrl;
      1: r = c.features;
      2: r = c.sec_cnt;
      3: r = c.sec_num;
      4: r = c.cyl_lo;
      5: r = c.cyl_hi;
      6: r = c.dev_head;
      7: r = c.command;
      default: r = c.stamp_ms[8*(b-ERR_CMD_REGS) +: 8];
    endcase
    return r;
  endfunction : cmd_byte

  function automatic logic [7:0] err_byte(input err_rec_t e,
                                          input int q);
    logic [7:0] r;
    r = 8'h00;
    case (q)
      1: r = e.error;
      2: r = e.sec_cnt;
      3: r = e.sec_num;
      4: r = e.cyl_lo;
      5: r = e.cyl_hi;
      6: r = e.dev_head;
      7: r = e.status;
      ERR_STATE_OFF: r = {e.state_vendor, e.state_code};
      ERR_HOURS_OFF: r = e.hours[7:0];
      ERR_HOURS_OFF + 1: r = e.hours[15:8];
      default: r = 8'h00;
    endcase
    return r;
  endfunction : err_byte

  function automatic logic [7:0] st_byte(input selftest_t d,
                                         input int o);
    logic [7:0] r;
    r = 8'h00;
    case (o)
      0: r = d.number;
      1: r = d.status;
      2: r = d.hours[7:0];
      3: r = d.hours[15:8];
      4: r = d.checkpoint;
      5, 6, 7, 8: r = d.lba[8*(o-5) +: 8];
      default: r = 8'h00;
    endcase
    return r;
  endfunction : st_byte

  function automatic logic [7:0] byte_of(input logic [2:0] k,
                                         input logic [8:0] a);
    int i, e, o;
    logic [7:0] r;
    i = int'(a);
    r = 8'h00;
    case (k)
      KIND_THRESH: begin
        if (i < 2) begin
          r = THR_REV[8*i +: 8];
        end else if (a < THR_END) begin
          e = (i - int'(THR_BASE)) / THR_ENTRY;
          o = (i - int'(THR_BASE)) % THR_ENTRY;
          if (o == 0) begin
            r = attr_id[e];
          end else if (o == THR_VAL_OFF) begin
            r = THRESH_VALUES[e];
          end
        end else if (a == CSUM_OFF) begin
          r = csum[0];
        end
      end
      KIND_DIR: begin
        if (i == 0) begin
          r = DIR_VERSION;
        end else if (i > 1 && a[0] == 1'b0) begin
          if (a[8:1] >= DIR_WIDE_LO && a[8:1] <= DIR_WIDE_HI) begin
            r = DIR_WIDE_SECTORS;
          end
        end
      end
      KIND_ERRLOG: begin
        if (i == 0) begin
          r = ERR_VERSION;
        end else if (i == 1) begin
          r = {5'h00, err_idx};
        end else if (a < ERR_COUNT_OFF) begin
          e = (i - int'(ERR_BASE)) / ERR_REC_LEN;
          o = (i - int'(ERR_BASE)) % ERR_REC_LEN;
          if (o < ERR_DATA_OFF) begin
            r = cmd_byte(err_slot[e].cmds[o / ERR_CMD_LEN],
                         o % ERR_CMD_LEN);
          end else begin
            r = err_byte(err_slot[e].err, o - ERR_DATA_OFF);
          end
        end else if (a == ERR_COUNT_OFF) begin
          r = err_count[7:0];
        end else if (a == ERR_COUNT_OFF + 9'h001) begin
          r = err_count[15:8];
        end else if (a == CSUM_OFF) begin
          r = csum[1];
        end
      end
      KIND_SELFTEST: begin
        if (i < 2) begin
          r = ST_REVISION[8*i +: 8];
        end else if (a < ST_END) begin
          e = (i - int'(ST_BASE)) / ST_DESC_LEN;
          o = (i - int'(ST_BASE)) % ST_DESC_LEN;
          r = st_byte(st_slot[e], o);
        end else if (a == ST_INDEX_OFF) begin
          r = {3'h0, st_idx};
        end else if (a == CSUM_OFF) begin
          r = csum[2];
        end
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction : byte_of

  function automatic logic [2:0] sel_kind(input logic [1:0] s);
    return (s == 2'd0) ? KIND_THRESH :
           (s == 2'd1) ? KIND_ERRLOG : KIND_SELFTEST;
  endfunction : sel_kind

  // ------------------------------------------------------------
  // error log
  // ------------------------------------------------------------
  // the first error goes to slot 0 and sets the index to 1, so the index never leaves 1..5
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      err_idx <= RST_ERR_IDX;
      err_count <= 16'h0000;
      for (int s = 0; s < ERR_SLOTS; s++) begin
        err_slot[s] <= '0;
      end
    end else if (ce && err_valid) begin
      if (err_count == 16'h0000 || err_idx == 3'(ERR_SLOTS)) begin
        err_idx <= 3'h1;
        err_slot[0] <= err_event;
      end else begin
        err_idx <= err_idx + 3'h1;
        err_slot[err_idx] <= err_event;
      end
      if (err_count != 16'hffff) begin
        err_count <= err_count + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // self-test log
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_idx <= 5'h00;
      for (int s = 0; s < ST_SLOTS; s++) begin
        st_slot[s] <= '0;
      end
    end else if (ce && st_valid) begin
      if (st_idx == 5'(ST_SLOTS)) begin
        st_idx <= 5'h01;
        st_slot[0] <= st_result;
      end else begin
        st_idx <= st_idx + 5'h01;
        st_slot[st_idx] <= st_result;
      end
    end
  end

  // ------------------------------------------------------------
  // checksum scanner
  // ------------------------------------------------------------
  // one byte per cycle keeps the adder small; a sector takes
  // 511 cycles and a change during a scan forces a rescan
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      attr_id_q <= '0;
    end else if (ce) begin
      attr_id_q <= attr_id;
    end
  end

  assign dirty_set = {st_valid, err_valid, attr_id != attr_id_q};
  assign next_sel = dirty[0] ? 2'd0 : dirty[1] ? 2'd1 : 2'd2;
  assign dirty_clr = (scan_state == SCAN_IDLE && dirty != 3'h0) ?
                     (3'h1 << next_sel) : 3'h0;
  // a process, not an assign, so the byte follows the stored logs too
  always_comb begin
    scan_byte = byte_of(sel_kind(scan_sel), scan_addr);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dirty <= 3'h7;
    end else if (ce) begin
      dirty <= (dirty & ~dirty_clr) | dirty_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scan_state <= SCAN_IDLE;
      scan_sel <= 2'd0;
      scan_addr <= 9'h000;
      scan_acc <= 8'h00;
      for (int s = 0; s < 3; s++) begin
        csum[s] <= 8'h00;
      end
    end else if (ce) begin
      case (scan_state)
        SCAN_IDLE: begin
          if (dirty != 3'h0) begin
            scan_sel <= next_sel;
            scan_addr <= 9'h000;
            scan_acc <= 8'h00;
            scan_state <= SCAN_RUN;
          end
        end
        SCAN_RUN: begin
          scan_acc <= scan_acc + scan_byte;
          if (scan_addr == LAST_SUMMED) begin
            csum[scan_sel] <= 8'h00 - (scan_acc + scan_byte);
            scan_state <= SCAN_IDLE;
          end else begin
            scan_addr <= scan_addr + 9'h001;
          end
        end
        default: scan_state <= SCAN_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // attribute sector tail
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      smart_cap <= 16'h0000;
      errlog_cap <= 8'h00;
      attr_checksum <= 8'h00;
    end else if (ce) begin
      smart_cap <= 16'h0000;
      smart_cap[0] <= prepower_save;
      smart_cap[CAP_AUTOSAVE_BIT] <= autosave_supported;
      errlog_cap <= 8'h00;
      errlog_cap[ERRLOG_CAP_BIT] <= errlog_supported;
      attr_checksum <= 8'h00 - (attr_partial_sum + smart_cap[7:0] +
                       smart_cap[15:8] + errlog_cap + times.short_min +
                       times.ext_min + times.ext_word[7:0] +
                       times.ext_word[15:8]);
    end
  end

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign pready = ce;
  assign acc_setup = ce && psel && !penable;
  assign acc_done = ce && psel && penable;
  assign wr = acc_done && pwrite;
  assign mapped = paddr == OFF_CTRL || paddr == OFF_ADDR ||
                  paddr == OFF_DATA || paddr == OFF_STATUS ||
                  paddr == OFF_TIMES || paddr == OFF_ATTR;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      kind <= KIND_THRESH;
      addr <= 9'h000;
      times <= '0;
    end else begin
      if (wr && paddr == OFF_CTRL) begin
        kind <= pwdata[2:0];
      end
      if (wr && paddr == OFF_TIMES) begin
        times <= pwdata;
      end
      if (wr && paddr == OFF_ADDR) begin
        addr <= pwdata[8:0];
      end else if (acc_done && !pwrite && paddr == OFF_DATA) begin
        addr <= addr + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (acc_setup) begin
      case (paddr)
        OFF_CTRL: prdata <= {29'h0, kind};
        OFF_ADDR: prdata <= {23'h0, addr};
        OFF_DATA: prdata <= {24'h0, byte_of(kind, addr)};
        OFF_STATUS: prdata <= {err_count, 3'h0, st_idx, 1'b0,
                               err_idx, 1'b0, dirty |
                               ((scan_state == SCAN_RUN) ?
                               (3'h1 << scan_sel) : 3'h0)};
        OFF_TIMES: prdata <= times;
        OFF_ATTR: prdata <= {attr_checksum, errlog_cap, smart_cap};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_err_log;
    ce && err_valid;
  endsequence
  sequence s_st_full;
    ce && st_valid && st_idx == 5'd21;
  endsequence

  a_err_index: assert property (@(posedge clk_sys) disable iff (reset)
    err_idx >= 3'd1 && err_idx <= 3'd5)
    else $error("error index out of range");
  a_err_step: assert property (@(posedge clk_sys) disable iff (reset)
    s_err_log ##0 (err_count != 16'hffff) |=>
    err_count == $past(err_count) + 16'h0001)
    else $error("error count did not step by one");
  a_err_nowrap: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) && $past(err_count) != 16'h0000 |->
    err_count != 16'h0000)
    else $error("error count wrapped");
  a_st_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    s_st_full |=> st_idx == 5'd1 &&
    st_slot[0] == $past(st_result))
    else $error("self-test log did not wrap");
  a_st_range: assert property (@(posedge clk_sys) disable iff (reset)
    st_idx <= 5'd21)
    else $error("self-test index out of range");
  a_dir_wide: assert property (@(posedge clk_sys) disable iff (reset)
    byte_of(KIND_DIR, 9'h100) == 8'h10 &&
    byte_of(KIND_DIR, 9'h13e) == 8'h10 &&
    byte_of(KIND_DIR, 9'h140) == 8'h00 &&
    byte_of(KIND_DIR, 9'h000) == 8'h01)
    else $error("directory content wrong");
  a_thr_layout: assert property (@(posedge clk_sys) disable iff (reset)
    byte_of(KIND_THRESH, 9'h000) == 8'h10 &&
    byte_of(KIND_THRESH, 9'h00e) == attr_id[1] &&
    byte_of(KIND_THRESH, 9'h004) == 8'h00 &&
    byte_of(KIND_THRESH, 9'h16a) == 8'h00)
    else $error("threshold layout wrong");
  a_scan_len: assert property (@(posedge clk_sys) disable iff (reset)
    ce && scan_state == SCAN_IDLE && dirty != 3'h0 |=>
    scan_state == SCAN_RUN ##1 scan_addr == 9'h001)
    else $error("checksum scan did not start");
  a_cap_bits: assert property (@(posedge clk_sys) disable iff (reset)
    ce && !$past(reset) && $past(ce) |->
    smart_cap[15:2] == 14'h0 && errlog_cap[7:1] == 7'h0)
    else $error("reserved capability bits set");
endmodule : smart_log_sector_builder
`default_nettype wire

// File: smart_host.sv
// apb host model that fetches smart log sectors
`timescale 1ns/10ps
`default_nettype none
module smart_host (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // request held until pready is seen high at an edge; no fixed latency
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : xfer
endmodule : smart_host
`default_nettype wire

// File: smart_log_sector_builder_test.sv
// self-checking bench for the smart log sector builder
`timescale 1ns/10ps
`default_nettype none
module smart_log_sector_builder_test;
  import smart_log_pkg::*;
  localparam logic [29:0][7:0] TV = {15{8'h21, 8'h4c}};
  logic clk_sys, reset, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, attr_partial_sum, attr_checksum, errlog_cap;
  logic [31:0] pwdata, prdata, seed, v, w;
  logic [29:0][7:0] attr_id;
  logic prepower_save, autosave_supported, errlog_supported;
  logic err_valid, st_valid, e;
  err_event_t err_event;
  err_event_t evs[7];
  selftest_t st_result;
  selftest_t sts[22];
  logic [15:0] smart_cap;
  times_t times;
  logic [7:0] sec[512];
  logic [575:0] tmp;
  int fail_count, comparisons, i, k;
  smart_log_sector_builder #(.THRESH_VALUES(TV)) i_smart_log_sector_builder (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .attr_id(attr_id), .attr_partial_sum(attr_partial_sum),
    .prepower_save(prepower_save), .autosave_supported(autosave_supported),
    .errlog_supported(errlog_supported), .err_valid(err_valid),
    .err_event(err_event), .st_valid(st_valid), .st_result(st_result),
    .smart_cap(smart_cap), .errlog_cap(errlog_cap), .times(times),
    .attr_checksum(attr_checksum));
  smart_host i_smart_host (.clk_sys(clk_sys), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    i_smart_host.xfer(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_smart_host.xfer(1'b1, a, d, v, e);
  endtask : wr
  // rescans finish before the sector is fetched, else checksum is stale
  task automatic rd_sec(input logic [2:0] kind, input logic [2:0] m);
    int n;
    n = 0;
    v = 32'h1;
    while ((v[2:0] & m) != 3'h0 && n < 3000) begin
      rd(OFF_STATUS, v);
      n++;
    end
    chk(v[2:0] & m, 0);
    wr(OFF_CTRL, {29'h0, kind});
    wr(OFF_ADDR, 32'h0);
    for (int j = 0; j < 512; j++) begin
      rd(OFF_DATA, v);
      sec[j] = v[7:0];
    end
  endtask : rd_sec
  task automatic chk_sum();
    logic [7:0] s;
    s = 8'h00;
    for (int j = 0; j < 512; j++) s += sec[j];
    chk(s, 0);
  endtask : chk_sum
  function automatic logic [7:0] eb(err_event_t ev, int b);
    cmd_rec_t c;
    if (b < 60) begin
      c = ev.cmds[b / 12];
      if (b % 12 < 8) return c[95 - 8 * (b % 12) -: 8];
      return c.stamp_ms[8 * (b % 12 - 8) +: 8];
    end
    if (b == 60) return 8'h00;
    if (b < 68) return ev.err[79 - 8 * (b - 61) -: 8];
    if (b == 87) return ev.err[23:16];
    return ev.err.hours[8 * (b - 88) +: 8];
  endfunction : eb
  function automatic logic [7:0] sb(selftest_t s, int b);
    if (b == 0) return s.number;
    if (b == 1) return s.status;
    if (b < 4) return s.hours[8 * (b - 2) +: 8];
    if (b == 4) return s.checkpoint;
    return s.lba[8 * (b - 5) +: 8];
  endfunction : sb
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    #1800000;
    fail_count++;
    stop_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h0f83;
    reset = 1'b1;
    ce = 1'b1;
    err_valid = 1'b0;
    st_valid = 1'b0;
    err_event = '0;
    st_result = '0;
    attr_partial_sum = 8'($random(seed));
    for (i = 0; i < 30; i++) attr_id[i] = 8'($random(seed));
    {prepower_save, autosave_supported, errlog_supported} = 3'($random(seed));
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(OFF_STATUS, v);
    chk(v & 32'hfffffff8, 32'h10);
    rd(OFF_ATTR, v);
    chk(v[23:0], {7'h0, errlog_supported, 14'h0, autosave_supported,
        prepower_save});
    w = $random(seed);
    wr(OFF_TIMES, w);
    rd(OFF_TIMES, v);
    chk(v, w);
    repeat (3) @(posedge clk_sys);
    rd(OFF_ATTR, v);
    chk(v[31:24], 8'(8'h00 - (attr_partial_sum + prepower_save
        + 2 * autosave_supported + errlog_supported + w[7:0] + w[15:8]
        + w[23:16] + w[31:24])));
    i_smart_host.xfer(1'b0, 8'h20, 32'h0, v, e);
    chk(v, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test registers done");
    rd_sec(KIND_DIR, 3'h0);
    for (i = 0; i < 512; i++)
      chk(sec[i], i == 0 ? 8'h01 : (i % 2 == 0 && i >= 'h100 && i < 'h140)
          ? 8'h10 : 8'h00);
    $display("test directory done");
    rd_sec(KIND_THRESH, 3'h1);
    for (i = 0; i < 511; i++)
      chk(sec[i], i == 0 ? 8'h10 : (i < 2 || i >= 'h16a) ? 8'h00
          : (i - 2) % 12 == 0 ? attr_id[(i - 2) / 12] : (i - 2) % 12 == 1
          ? TV[(i - 2) / 12] : 8'h00);
    chk_sum();
    $display("test thresholds done");
    for (i = 0; i < 7; i++) begin
      for (k = 0; k < 18; k++) tmp[32 * k +: 32] = $random(seed);
      evs[i] = tmp[$bits(err_event_t)-1:0];
      err_event <= evs[i];
      err_valid <= 1'b1;
      @(posedge clk_sys);
    end
    err_valid <= 1'b0;
    rd(OFF_STATUS, v);
    chk({v[31:16], v[6:4]}, {16'h7, 3'h2});
    rd_sec(KIND_ERRLOG, 3'h2);
    chk({sec['h1c5], sec['h1c4], sec[1], sec[0]}, 32'h00070201);
    for (k = 0; k < 90; k++) begin
      if (k < 68 || k > 86) begin
        chk(sec[2 + k], eb(evs[5], k));
        chk(sec[92 + k], eb(evs[6], k));
      end
    end
    chk_sum();
    $display("test error log done");
    for (i = 0; i < 22; i++) begin
      for (k = 0; k < 3; k++) tmp[32 * k +: 32] = $random(seed);
      sts[i] = tmp[71:0];
      st_result <= sts[i];
      st_valid <= 1'b1;
      @(posedge clk_sys);
    end
    st_valid <= 1'b0;
    rd_sec(KIND_SELFTEST, 3'h4);
    chk({sec['h1fc], sec[1], sec[0]}, 24'h010001);
    for (k = 0; k < 9; k++) begin
      chk(sec[2 + k], sb(sts[21], k));
      chk(sec[26 + k], sb(sts[1], k));
    end
    chk_sum();
    $display("test self-test log done");
    ce <= 1'b0;
    err_valid <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ce <= 1'b1;
    err_valid <= 1'b0;
    rd(OFF_STATUS, v);
    chk({v[31:16], v[6:4]}, {16'h7, 3'h2});
    $display("test clock enable done");
    err_valid <= 1'b1;
    repeat (65540) @(posedge clk_sys);
    err_valid <= 1'b0;
    rd(OFF_STATUS, v);
    chk({v[31:16], v[6:4]}, {16'hffff, 3'h2});
    $display("test saturation done");
    stop_test();
  end
endmodule : smart_log_sector_builder_test
`default_nettype wire
